// ---- pkg/rrb_params.svh ----
// Purpose: constants of the clock register bank
// Assumes: byte-wide registers, 5-bit register pointer
// Notes:   included by rrb_bank
`ifndef RRB_PARAMS_SVH
`define RRB_PARAMS_SVH

`define RRB_OFS_CONTROL_ONE   5'h00
`define RRB_OFS_CLOCK_OUTPUT_CTL    5'h0f
`define RRB_OFS_WDT_CTL       5'h10
`define RRB_OFS_WDT_VAL       5'h11
`define RRB_OFS_CAP_CTL       5'h12
`define RRB_OFS_CAP_SEC       5'h13
`define RRB_OFS_CAP_MIN       5'h14
`define RRB_OFS_CAP_HOUR      5'h15
`define RRB_OFS_CAP_DAY       5'h16
`define RRB_OFS_CAP_MON       5'h17
`define RRB_OFS_CAP_YEAR      5'h18
`define RRB_OFS_AGING         5'h19
`define RRB_OFS_RAM_HI        5'h1a
`define RRB_OFS_RAM_LO        5'h1b
`define RRB_OFS_RAM_WR        5'h1c
`define RRB_OFS_RAM_RD        5'h1d
`define RRB_OFS_LAST_AUTO     5'h1b
`define RRB_OFS_TIME_FIRST    5'h03
`define RRB_OFS_TIME_LAST     5'h09

`define RRB_BIT_EXTERNAL_CLOCK_TEST_SELECT      7
`define RRB_BIT_RSVD_T        6
`define RRB_BIT_STOP          5
`define RRB_BIT_CAPFLAG       4
`define RRB_BIT_OVRD          3
`define RRB_BIT_HOUR12        2

`define RRB_RST_CONTROL_ONE   8'h00
`define RRB_RST_CLOCK_OUTPUT_CTL    8'h00
`define RRB_RST_WDT_CTL       8'h03
`define RRB_RST_AGING         8'h08
`define RRB_RST_RAM_PTR       8'h00

`define RRB_MASK_CLOCK_OUTPUT_CTL   8'hc7
`define RRB_MASK_WDT_CTL      8'he3
`define RRB_MASK_CAP_CTL      8'hdf
`define RRB_MASK_AGING        8'h0f
`define RRB_MASK_CAP_SEC      8'h7f
`define RRB_MASK_CAP_MIN      8'h7f
`define RRB_MASK_CAP_HOUR     8'h3f
`define RRB_MASK_CAP_DAY      8'h3f
`define RRB_MASK_CAP_MON      8'h1f
`define RRB_MASK_RAM_HI       8'h01

// square wave source frequency of 32.768 kHz and select field width
`define RRB_OSC_KHZ_X1000     32768
`define RRB_SQUARE_WAVE_OUTPUT_SEL_W      3

`endif

// ---- pkg/rrb_pkg.sv ----
// Purpose: types of the clock register bank
// Assumes: constants live in rrb_params.svh
// Notes:   host access travels as one struct
package rrb_pkg;
  typedef struct packed {
    logic       start;
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } rrb_acc_s;

  typedef struct packed {
    logic external_clock_test_select;
    logic stop;
    logic capflag;
    logic ovrd;
    logic hour12;
  } rrb_ctl_s;

  typedef enum logic [1:0] {
    RRB_IDLE  = 2'b00,
    RRB_FROZE = 2'b01
  } rrb_state_e;
endpackage

// ---- rtl/rrb_bank.sv ----
// Purpose: register bank and first control register of a clock chip
// Assumes: serial interface decoded outside into byte accesses
// Notes:   time, alarm and capture counting live elsewhere
`timescale 1ns/10ps
`include "rrb_params.svh"

// Behaviour
// - unimplemented bit positions always read back as zero.
// - undefined bits keep their value through later resets.
// - stop bit halts timekeeping clock and clears divider chain.
// - top three square wave frequencies still run while stopped.
// - bit 7 selects normal or external clock test mode.
// - intermediate capture level sets flag 4; host clears it.
// - bit 3 enables power-on reset override facility.
// - bit 2 selects 24-hour or 12-hour counting.
// - pointer increments per byte, wraps to zero after 1Bh.
// - counters freeze during any time register access.
module rrb_bank
  import rrb_pkg::*;
#(
  parameter int DIV_W = 15
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // host byte access, from serial interface logic
  input  wire rrb_acc_s   acc,
  output logic      [7:0] rdata_q,
  output logic      [4:0] ptr_q,
  // timekeeping oscillator tick (asynchronous)
  input  wire logic       osc_tick,
  // intermediate level detector on capture_trigger_input
  input  wire logic       capture_mid_level,
  // control outputs and RAM read data input
  output rrb_ctl_s        ctl_q,
  output logic            counters_frozen_q,
  output logic            divider_clear_q,
  output logic [DIV_W-1:0] divider_q,
  output logic            square_wave_output_q,
  output logic [7:0]      ram_ptr_hi_q,
  output logic [7:0]      ram_ptr_lo_q,
  output logic            ram_wr_pulse_q,
  output logic            ram_rd_pulse_q,
  input  wire logic [7:0] ram_rdata
);
  // taps up to DIV_W-1 feed the square wave select
  if (DIV_W < 15) begin : g_div_chk
    $error("rrb_bank divider too short for 1 Hz output");
  end

  // synchronisers for asynchronous inputs
  logic [1:0] tick_sync_q;
  logic [1:0] mid_sync_q;
  logic       tick_prev_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_sync_q <= 2'b00;
      mid_sync_q  <= 2'b00;
      tick_prev_q <= 1'b0;
    end else begin
      tick_sync_q <= {tick_sync_q[0], osc_tick};
      mid_sync_q  <= {mid_sync_q[0], capture_mid_level};
      tick_prev_q <= tick_sync_q[1];
    end
  end
  // edges found after the second flop only
  wire tick_rise = tick_sync_q[1] & ~tick_prev_q;
  wire mid_level = mid_sync_q[1];

  // access decode
  function automatic logic is_time_reg(input logic [4:0] a);
    return (a >= `RRB_OFS_TIME_FIRST) && (a <= `RRB_OFS_TIME_LAST);
  endfunction

  // one table serves both write storage and read-back masking
  function automatic logic [7:0] bit_mask(input logic [4:0] a);
    unique case (a)
      `RRB_OFS_CLOCK_OUTPUT_CTL: return `RRB_MASK_CLOCK_OUTPUT_CTL;
      `RRB_OFS_WDT_CTL:    return `RRB_MASK_WDT_CTL;
      `RRB_OFS_AGING:      return `RRB_MASK_AGING;
      `RRB_OFS_RAM_HI:     return `RRB_MASK_RAM_HI;
      `RRB_OFS_CAP_CTL:    return `RRB_MASK_CAP_CTL;
      `RRB_OFS_CAP_SEC:    return `RRB_MASK_CAP_SEC;
      `RRB_OFS_CAP_MIN:    return `RRB_MASK_CAP_MIN;
      `RRB_OFS_CAP_HOUR:   return `RRB_MASK_CAP_HOUR;
      `RRB_OFS_CAP_DAY:    return `RRB_MASK_CAP_DAY;
      `RRB_OFS_CAP_MON:    return `RRB_MASK_CAP_MON;
      default:             return 8'hff;
    endcase
  endfunction

  wire       acc_any  = acc.wr | acc.rd;
  // start restarts at the given address, else the pointer leads
  wire [4:0] cur_addr = acc.start ? acc.addr : ptr_q;
  wire       wr_ctl1  = acc.wr && (cur_addr == `RRB_OFS_CONTROL_ONE);
  wire       wr_clko  = acc.wr && (cur_addr == `RRB_OFS_CLOCK_OUTPUT_CTL);
  wire       wr_wdtc  = acc.wr && (cur_addr == `RRB_OFS_WDT_CTL);
  wire       wr_age   = acc.wr && (cur_addr == `RRB_OFS_AGING);
  wire       wr_rhi   = acc.wr && (cur_addr == `RRB_OFS_RAM_HI);
  wire       wr_rlo   = acc.wr && (cur_addr == `RRB_OFS_RAM_LO);
  wire       wr_rcmd  = acc.wr && (cur_addr == `RRB_OFS_RAM_WR);
  wire       rd_rcmd  = acc.rd && (cur_addr == `RRB_OFS_RAM_RD);
  // undefined-at-power-on registers live in the no-reset memory
  wire       mem_wr   = acc.wr && ((cur_addr == `RRB_OFS_WDT_VAL) ||
                                   (cur_addr == `RRB_OFS_CAP_CTL) ||
                                   ((cur_addr >= `RRB_OFS_TIME_FIRST) &&
                                    (cur_addr <= `RRB_OFS_TIME_LAST)) ||
                                   ((cur_addr > `RRB_OFS_CONTROL_ONE) &&
                                    (cur_addr < `RRB_OFS_TIME_FIRST)) ||
                                   ((cur_addr > `RRB_OFS_TIME_LAST) &&
                                    (cur_addr < `RRB_OFS_CLOCK_OUTPUT_CTL)));

  wire [4:0] ptr_d = (cur_addr >= `RRB_OFS_LAST_AUTO) ? 5'h00
                                                       : cur_addr + 5'h01;

  // registers with reset
  logic [7:0] clko_q;
  logic [7:0] wdtc_q;
  logic [7:0] age_q;
  logic [7:0] mem_rdata;
  logic       rd_mem_q;
  logic [7:0] mux_q;
  logic [4:0] last_addr_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 5'h00;
    end else if (acc_any) begin
      ptr_q <= ptr_d;
    end
  end

  // control one fields
  wire [7:0] c1_w = acc.wdata;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= '0;
    end else begin
      if (wr_ctl1) begin
        ctl_q.external_clock_test_select <= c1_w[`RRB_BIT_EXTERNAL_CLOCK_TEST_SELECT];
        ctl_q.stop     <= c1_w[`RRB_BIT_STOP];
        ctl_q.ovrd     <= c1_w[`RRB_BIT_OVRD];
        ctl_q.hour12   <= c1_w[`RRB_BIT_HOUR12];
      end
      if (mid_level) begin
        ctl_q.capflag <= 1'b1;
      end else if (wr_ctl1 && !c1_w[`RRB_BIT_CAPFLAG]) begin
        ctl_q.capflag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clko_q       <= `RRB_RST_CLOCK_OUTPUT_CTL;
      wdtc_q       <= `RRB_RST_WDT_CTL;
      age_q        <= `RRB_RST_AGING;
      ram_ptr_hi_q <= `RRB_RST_RAM_PTR;
      ram_ptr_lo_q <= `RRB_RST_RAM_PTR;
    end else begin
      if (wr_clko) clko_q <= acc.wdata & bit_mask(cur_addr);
      if (wr_wdtc) wdtc_q <= acc.wdata & bit_mask(cur_addr);
      if (wr_age)  age_q  <= acc.wdata & bit_mask(cur_addr);
      if (wr_rhi)  ram_ptr_hi_q <= acc.wdata & bit_mask(cur_addr);
      if (wr_rlo)  ram_ptr_lo_q <= acc.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ram_wr_pulse_q <= 1'b0;
      ram_rd_pulse_q <= 1'b0;
    end else begin
      ram_wr_pulse_q <= wr_rcmd;
      ram_rd_pulse_q <= rd_rcmd;
    end
  end

  rrb_mem #(.DEPTH(32), .AW(5)) u_mem (
    .mclk  (mclk),
    .we    (mem_wr),
    .waddr (cur_addr),
    .wdata (acc.wdata),
    .raddr (cur_addr),
    .rdata (mem_rdata)
  );

  // read mux, registered; memory-backed reads resolved a cycle later
  wire [7:0] ctl1_rd = {ctl_q.external_clock_test_select, 1'b0, ctl_q.stop, ctl_q.capflag,
                        ctl_q.ovrd, ctl_q.hour12, 2'b00};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mux_q       <= 8'h00;
      rd_mem_q    <= 1'b0;
      last_addr_q <= 5'h00;
    end else begin
      rd_mem_q    <= acc.rd;
      last_addr_q <= cur_addr;
      if (acc.rd) begin
        unique case (cur_addr)
          `RRB_OFS_CONTROL_ONE: mux_q <= ctl1_rd;
          `RRB_OFS_CLOCK_OUTPUT_CTL:  mux_q <= clko_q;
          `RRB_OFS_WDT_CTL:     mux_q <= wdtc_q;
          `RRB_OFS_AGING:       mux_q <= age_q;
          `RRB_OFS_RAM_HI:      mux_q <= ram_ptr_hi_q;
          `RRB_OFS_RAM_LO:      mux_q <= ram_ptr_lo_q;
          `RRB_OFS_RAM_RD:      mux_q <= ram_rdata;
          default:              mux_q <= 8'h00;
        endcase
      end
    end
  end

  wire from_mem = (last_addr_q != `RRB_OFS_CONTROL_ONE) &&
                  (last_addr_q != `RRB_OFS_CLOCK_OUTPUT_CTL) &&
                  (last_addr_q != `RRB_OFS_WDT_CTL) &&
                  (last_addr_q != `RRB_OFS_AGING) &&
                  (last_addr_q != `RRB_OFS_RAM_HI) &&
                  (last_addr_q != `RRB_OFS_RAM_LO) &&
                  (last_addr_q != `RRB_OFS_RAM_RD) &&
                  (last_addr_q <= `RRB_OFS_RAM_RD);
  wire [7:0] mem_masked = mem_rdata & bit_mask(last_addr_q);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_mem_q) begin
      rdata_q <= from_mem ? mem_masked : mux_q;
    end
  end

  // freeze counters during time register access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      counters_frozen_q <= 1'b0;
    end else begin
      counters_frozen_q <= acc_any && is_time_reg(cur_addr);
    end
  end

  // stop clears the divider chain at once, not at an edge
  // derived from rst_n and the stop flop only, so the clear cannot glitch
  wire div_rst_n = rst_n & ~ctl_q.stop;
  always_ff @(posedge mclk or negedge div_rst_n) begin
    if (!div_rst_n) begin
      divider_q <= '0;
    end else if (tick_rise && !counters_frozen_q) begin
      divider_q <= divider_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      divider_clear_q <= 1'b0;
    end else begin
      divider_clear_q <= ctl_q.stop;
    end
  end

  // prescaler for 16/8 kHz runs regardless of stop
  logic [2:0] pre_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 3'h0;
    end else if (tick_rise) begin
      pre_q <= pre_q + 3'h1;
    end
  end

  wire [2:0] sel = clko_q[`RRB_SQUARE_WAVE_OUTPUT_SEL_W-1:0];
  logic      sq_d;
  always_comb begin
    unique case (sel)
      3'h0:    sq_d = tick_sync_q[1];
      3'h1:    sq_d = pre_q[0];
      3'h2:    sq_d = pre_q[1];
      3'h3:    sq_d = divider_q[2];
      3'h4:    sq_d = divider_q[4];
      3'h5:    sq_d = divider_q[9];
      3'h6:    sq_d = divider_q[DIV_W-1];
      default: sq_d = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      square_wave_output_q <= 1'b0;
    end else begin
      square_wave_output_q <= sq_d;
    end
  end
endmodule // rrb_bank

// ---- rtl/rrb_mem.sv ----
// Purpose: small byte memory for values without reset
// Assumes: one write and one read port, registered read data
// Notes:   no reset, contents kept across resets
`timescale 1ns/10ps
module rrb_mem #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock
  input  wire logic          mclk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_depth_chk
    $error("rrb_mem depth exceeds address range");
  end

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // rrb_mem

// ---- verif/rrb_bank_sva.sv ----
// Purpose: port checker of the clock register bank
// Assumes: access taken at the edge, answer two cycles on
// Notes:   sees only the ports of rrb_bank
`timescale 1ns/10ps
module rrb_bank_chk
  import rrb_pkg::*;
#(
  parameter int DIV_W = 15
) (
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst_n,
  // watched ports
  input wire rrb_acc_s         acc,
  input wire logic [7:0]       rdata_q,
  input wire logic [4:0]       ptr_q,
  input wire logic             capture_mid_level,
  input wire rrb_ctl_s         ctl_q,
  input wire logic             counters_frozen_q,
  input wire logic             divider_clear_q,
  input wire logic [DIV_W-1:0] divider_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic       go = acc.wr | acc.rd;
  wire logic [4:0] ea = acc.start ? acc.addr : ptr_q;
  sequence s_quiet; !capture_mid_level [*4]; endsequence
  sequence s_ctl_wr; acc.wr && ea == 5'h00; endsequence
  chk_ptr_step: assert property (
    go && ea < 5'h1b |=> ptr_q == $past(ea) + 5'h01)
    else $error("pointer did not step");
  chk_ptr_wrap: assert property (
    go && ea == 5'h1b |=> ptr_q == 5'h00)
    else $error("pointer did not wrap");
  // single read so the answer is not overwritten
  chk_unused_zero: assert property (
    acc.rd && ea == 5'h0f ##1 !acc.rd |-> ##2 rdata_q[5:3] == 3'h0)
    else $error("unused bits not zero");
  chk_stop_copy: assert property (
    ctl_q.stop [*2] |-> divider_clear_q)
    else $error("stop did not clear divider");
  chk_div_held: assert property (
    divider_clear_q |-> divider_q == '0)
    else $error("divider runs while stopped");
  chk_flag_set: assert property (
    capture_mid_level [*4] |-> ctl_q.capflag)
    else $error("capture flag not set");
  chk_flag_keep: assert property (
    s_quiet ##0 s_ctl_wr ##0 acc.wdata[4] && !ctl_q.capflag
    |=> !ctl_q.capflag)
    else $error("host set capture flag");
  chk_flag_clear: assert property (
    s_quiet ##0 s_ctl_wr ##0 !acc.wdata[4] |=> !ctl_q.capflag)
    else $error("capture flag not cleared");
  chk_ctl_write: assert property (
    s_ctl_wr |=> {ctl_q.external_clock_test_select, ctl_q.stop, ctl_q.ovrd, ctl_q.hour12}
    == $past({acc.wdata[7], acc.wdata[5], acc.wdata[3:2]}))
    else $error("control bits not stored");
  chk_freeze_on: assert property (
    go && ea >= 5'h03 && ea <= 5'h09 |=> counters_frozen_q)
    else $error("counters not frozen");
endmodule // rrb_bank_chk

bind rrb_bank rrb_bank_chk #(.DIV_W(DIV_W)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .acc(acc), .rdata_q(rdata_q),
  .ptr_q(ptr_q), .capture_mid_level(capture_mid_level), .ctl_q(ctl_q),
  .counters_frozen_q(counters_frozen_q),
  .divider_clear_q(divider_clear_q), .divider_q(divider_q));

// ---- verif/rrb_host.sv ----
// Purpose: host side of the byte access port
// Assumes: caller enters 1 ns after a rising edge
// Notes:   request dropped on the edge that takes it
`timescale 1ns/10ps
module rrb_host
  import rrb_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // access port
  output rrb_acc_s        acc,
  input  wire logic [7:0] rdata_q
);
  initial acc = '0;
  task automatic go(input logic s, w, input logic [4:0] a,
                    input logic [7:0] d);
    acc = '{s, w, !w, a, a == 5'h00 ? d & 8'hbf : d};
    @(posedge mclk);
    acc <= '0;
    #1;
  endtask
  task automatic rd(input logic s, input logic [4:0] a,
                    output logic [7:0] d);
    go(s, 1'b0, a, 8'h00);
    repeat (2) @(posedge mclk);
    #1 d = rdata_q;
  endtask
endmodule // rrb_host

// ---- verif/tb.sv ----
// Purpose: self-checking bench of the clock register bank
// Assumes: host model drives the access port
// Notes:   oscillator tick runs at one eighth of mclk
`timescale 1ns/10ps
module tb;
  import rrb_pkg::*;
  logic       mclk, rst_n, osc_tick, capture_mid_level, sq;
  rrb_acc_s   acc;
  wire        rrb_ctl_s ctl;
  wire [7:0]  rdata_q;
  wire [4:0]  ptr_q;
  wire        sw;
  logic [7:0] d;
  wire        ramw, ramr;
  int         err_total, checks_done, cyc, n, pulses;

  rrb_host host (.mclk(mclk), .acc(acc), .rdata_q(rdata_q));
  rrb_bank #(.DIV_W(15)) dut (.mclk(mclk), .rst_n(rst_n), .acc(acc),
    .rdata_q(rdata_q), .ptr_q(ptr_q), .osc_tick(osc_tick),
    .capture_mid_level(capture_mid_level), .ctl_q(ctl),
    .counters_frozen_q(), .divider_clear_q(), .divider_q(),
    .square_wave_output_q(sw), .ram_ptr_hi_q(), .ram_ptr_lo_q(),
    .ram_wr_pulse_q(ramw), .ram_rd_pulse_q(ramr), .ram_rdata(8'h3c));

  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  // tick edges fall on falling clock edges, between rising edges, on purpose
  initial begin
    osc_tick = 0;
    forever #32 osc_tick = ~osc_tick;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end
  end
  always @(posedge mclk) pulses += int'(ramw) + int'(ramr);

  task automatic chk(input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    host.go(1'b1, 1'b1, a, v);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    host.rd(1'b1, a, d);
    chk(d, e);
  endtask
  // settle two edges after the select change, then count toggles
  task automatic tog(input logic [7:0] s, input int e);
    wr(5'h0f, s);
    repeat (2) @(posedge mclk);
    #1 sq = sw;
    n = 0;
    repeat (64) begin
      @(posedge mclk);
      #1 n += int'(sq !== sw);
      sq = sw;
    end
    chk(8'(n), 8'(e));
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    rst_n = 0;
    capture_mid_level = 0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1;
    rdc(5'h0f, 8'h00);
    rdc(5'h10, 8'h03);
    rdc(5'h19, 8'h08);
    rdc(5'h1a, 8'h00);
    rdc(5'h1b, 8'h00);
    wr(5'h0f, 8'hff);
    rdc(5'h0f, 8'hc7);
    wr(5'h1a, 8'hff);
    rdc(5'h1a, 8'h01);
    wr(5'h19, 8'hff);
    rdc(5'h19, 8'h0f);
    wr(5'h12, 8'hff);
    rdc(5'h12, 8'hdf);
    host.rd(1'b1, 5'h15, d);
    chk(d & 8'hc0, 8'h00);
    wr(5'h1c, 8'h55);
    rdc(5'h1d, 8'h3c);
    chk(8'(pulses), 8'h02);
    $display("test reset and unused bits done");
    wr(5'h00, 8'hbc);
    chk({3'h0, ctl}, 8'h1b);
    wr(5'h1b, 8'h00);
    chk({3'h0, ptr_q}, 8'h00);
    host.rd(1'b0, 5'h00, d);
    chk(d & 8'hfc, 8'hac);
    chk({3'h0, ptr_q}, 8'h01);
    $display("test control and pointer done");
    for (int s = 0; s < 3; s++) begin
      tog(8'(s), 16 >> s);
    end
    tog(8'h03, 0);
    $display("test stopped square wave done");
    capture_mid_level = 1;
    repeat (5) @(posedge mclk);
    #1 capture_mid_level = 0;
    chk({7'h0, ctl.capflag}, 8'h01);
    repeat (4) @(posedge mclk);
    #1 wr(5'h00, 8'h00);
    chk({7'h0, ctl.capflag}, 8'h00);
    tog(8'h03, 2);
    host.rd(1'b1, 5'h05, d);
    $display("test capture flag done");
    wr(5'h11, 8'h5a);
    rst_n = 0;
    @(posedge mclk);
    #1 rst_n = 1;
    chk({3'h0, ctl}, 8'h00);
    rdc(5'h11, 8'h5a);
    $display("test second reset done");
    final_report;
  end
endmodule // tb
